/* pdc_map.vh */
// Purpose: Register offsets, field positions, reset values and serial frame constants
//          for the PLL divider configuration block.
// Assumes: Byte-wide registers reached over a three-wire serial port.
// Notes:   Included by both design files; definitions only.
`ifndef PDC_MAP_VH
`define PDC_MAP_VH

// Register byte addresses.
`define PDC_ADDR_FB_HI 7'h00
`define PDC_ADDR_FB_LO 7'h01
`define PDC_ADDR_AUX_LO 7'h02
`define PDC_ADDR_AUX_HI 7'h03
`define PDC_ADDR_REF_HI 7'h04
`define PDC_ADDR_REF_LO 7'h05
`define PDC_ADDR_SFB_HI 7'h08
`define PDC_ADDR_SFB_LO 7'h09
`define PDC_ADDR_BYPASS 7'h0a
`define PDC_ADDR_SIN 7'h0c
`define PDC_ADDR_OSC 7'h1f

// Field positions inside the byte registers.
`define PDC_PHASE_MSB 7
`define PDC_PHASE_LSB 5
`define PDC_AUX_PD_BIT 4
`define PDC_HI_NIB_MSB 3
`define PDC_AUX_B8_BIT 7
`define PDC_FB_PATH_BIT 0
`define PDC_DOUBLER_BIT 7
`define PDC_SIN_MSB 5

// Reset values.
`define PDC_RST_FB_DIV 12'hc00
`define PDC_RST_REF_DIV 12'hc00
`define PDC_RST_AUX_DIV 9'h060
`define PDC_RST_SFB_DIV 9'h018
`define PDC_RST_SIN_DIV 6'h00
`define PDC_RST_PHASE 3'h0

// Lowest legal ratios and sample phase.
`define PDC_MIN_MAIN_DIV 12'h001
`define PDC_MIN_AUX_DIV 9'h004
`define PDC_MIN_SFB_DIV 9'h008
`define PDC_MIN_PHASE 3'h2

// Serial frame: read flag, 7 address bits, 8 data bits, most significant first.
`define PDC_FRAME_BITS 5'h10
`define PDC_ADDR_BITS 5'h08

`endif

/* pdc_spi_slave.v */
// Purpose: Three-wire serial slave that turns frames into register reads and writes.
// Assumes: Serial clock idles low; each half period lasts at least four clk cycles.
// Notes:   All pins pass two flip-flops before any logic looks at them.
`timescale 1ns/1ns
`include "pdc_map.vh"

module pdc_spi_slave (
    input wire clk,
    input wire srst,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_sdio_in,
    output reg spi_sdio_out,
    output reg spi_sdio_oe,
    input wire [7:0] rd_data,
    output reg [6:0] reg_addr,
    output reg [7:0] wr_data,
    output reg wr_stb
);
    reg sclk_s1_reg;
    reg sclk_s2_reg;
    reg sclk_s3_reg;
    reg cs_s1_reg;
    reg cs_s2_reg;
    reg din_s1_reg;
    reg din_s2_reg;
    reg [4:0] bit_cnt_reg;
    reg [6:0] shift_reg;
    reg [7:0] dout_reg;
    reg read_reg;
    reg load_reg;
    wire sclk_rise;
    wire sclk_fall;

    assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
    assign sclk_fall = ~sclk_s2_reg & sclk_s3_reg;

    always @(posedge clk) begin
        if (srst) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
            bit_cnt_reg <= 5'h00;
            shift_reg <= 7'h00;
            dout_reg <= 8'h00;
            read_reg <= 1'b0;
            load_reg <= 1'b0;
            reg_addr <= 7'h00;
            wr_data <= 8'h00;
            wr_stb <= 1'b0;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe <= 1'b0;
        end else begin
            sclk_s1_reg <= spi_sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            cs_s1_reg <= spi_cs_n;
            cs_s2_reg <= cs_s1_reg;
            din_s1_reg <= spi_sdio_in;
            din_s2_reg <= din_s1_reg;
            wr_stb <= 1'b0;
            load_reg <= 1'b0;
            if (cs_s2_reg) begin
                // Deselect aborts any partial frame, so a torn write never lands.
                bit_cnt_reg <= 5'h00;
                spi_sdio_oe <= 1'b0;
                read_reg <= 1'b0;
            end else begin
                if (sclk_rise && bit_cnt_reg != `PDC_FRAME_BITS) begin
                    shift_reg <= {shift_reg[5:0], din_s2_reg};
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    if (bit_cnt_reg == `PDC_ADDR_BITS - 5'h01) begin
                        reg_addr <= {shift_reg[5:0], din_s2_reg};
                        read_reg <= shift_reg[6];
                        load_reg <= shift_reg[6];
                    end
                    if (bit_cnt_reg == `PDC_FRAME_BITS - 5'h01 && !read_reg) begin
                        wr_data <= {shift_reg[6:0], din_s2_reg};
                        wr_stb <= 1'b1;
                    end
                end
                if (load_reg) begin
                    // Address is settled one cycle after capture, so read data is taken here.
                    dout_reg <= rd_data;
                    spi_sdio_out <= rd_data[7];
                    spi_sdio_oe <= 1'b1;
                end else if (sclk_fall && spi_sdio_oe) begin
                    dout_reg <= {dout_reg[6:0], 1'b0};
                    spi_sdio_out <= dout_reg[6];
                end
            end
        end
    end
endmodule

/* pdc_top.v */
// Purpose: Divider configuration registers of a two-stage clock PLL behind a serial port.
// Assumes: Pins come from outside the clk domain; reset is synchronous and active high.
// Notes:   Ratios are stored as written; out-of-range codes other than the sample phases and a powered-down aux ratio are flagged, not corrected.
`timescale 1ns/1ns
`include "pdc_map.vh"

module pdc_top (
    input wire clk,
    input wire srst,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_sdio_in,
    output wire spi_sdio_out,
    output wire spi_sdio_oe,
    output wire [11:0] vcxo_loop_feedback_divide,
    output wire [2:0] feedback_divider_sample_phase,
    output wire [8:0] aux_feedback_divide,
    output wire aux_divider_powerdown,
    output wire feedback_path_extend,
    output wire [2:0] ref_divider_sample_phase,
    output wire [11:0] ref_input_predivide,
    output wire [8:0] synth_feedback_predivide,
    output wire [5:0] synth_input_predivide,
    output wire doubler_select,
    output wire first_stage_bypass,
    output wire oscillator_select,
    output reg aux_divider_enable,
    output reg first_stage_loop_enable,
    output reg synth_ref_doubled,
    output reg synth_ref_div_bypass,
    output reg [5:0] synth_ref_divide_eff,
    output reg config_range_error
);
    reg [11:0] fb_div_reg;
    reg [2:0] fb_phase_reg;
    reg [8:0] aux_div_reg;
    reg aux_pd_reg;
    reg fb_path_reg;
    reg [2:0] ref_phase_reg;
    reg [11:0] ref_div_reg;
    reg [8:0] sfb_div_reg;
    reg [5:0] sin_div_reg;
    reg doubler_reg;
    reg bypass_reg;
    reg osc_sel_reg;
    reg [7:0] rd_data_next;
    reg range_error_next;
    wire [6:0] reg_addr;
    wire [7:0] wr_data;
    wire wr_stb;

    pdc_spi_slave pdc_spi_slave_inst (
        .clk(clk),
        .srst(srst),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_sdio_in(spi_sdio_in),
        .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe(spi_sdio_oe),
        .rd_data(rd_data_next),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .wr_stb(wr_stb)
    );

    // Register file; writes to unmapped addresses are dropped.
    always @(posedge clk) begin
        if (srst) begin
            fb_div_reg <= `PDC_RST_FB_DIV;
            ref_div_reg <= `PDC_RST_REF_DIV;
            aux_div_reg <= `PDC_RST_AUX_DIV;
            aux_pd_reg <= 1'b0;
            fb_phase_reg <= `PDC_RST_PHASE;
            ref_phase_reg <= `PDC_RST_PHASE;
            fb_path_reg <= 1'b0;
            sfb_div_reg <= `PDC_RST_SFB_DIV;
            sin_div_reg <= `PDC_RST_SIN_DIV;
            doubler_reg <= 1'b0;
            bypass_reg <= 1'b0;
            osc_sel_reg <= 1'b0;
        end else if (wr_stb) begin
            case (reg_addr)
                `PDC_ADDR_FB_HI: begin
                    fb_phase_reg <= wr_data[`PDC_PHASE_MSB:`PDC_PHASE_LSB];
                    aux_pd_reg <= wr_data[`PDC_AUX_PD_BIT];
                    fb_div_reg[11:8] <= wr_data[`PDC_HI_NIB_MSB:0];
                end
                `PDC_ADDR_FB_LO: begin
                    fb_div_reg[7:0] <= wr_data;
                end
                `PDC_ADDR_AUX_LO: begin
                    aux_div_reg[7:0] <= wr_data;
                end
                `PDC_ADDR_AUX_HI: begin
                    aux_div_reg[8] <= wr_data[`PDC_AUX_B8_BIT];
                    fb_path_reg <= wr_data[`PDC_FB_PATH_BIT];
                end
                `PDC_ADDR_REF_HI: begin
                    ref_phase_reg <= wr_data[`PDC_PHASE_MSB:`PDC_PHASE_LSB];
                    ref_div_reg[11:8] <= wr_data[`PDC_HI_NIB_MSB:0];
                end
                `PDC_ADDR_REF_LO: begin
                    ref_div_reg[7:0] <= wr_data;
                end
                `PDC_ADDR_SFB_HI: begin
                    sfb_div_reg[8] <= wr_data[0];
                end
                `PDC_ADDR_SFB_LO: begin
                    sfb_div_reg[7:0] <= wr_data;
                end
                `PDC_ADDR_BYPASS: begin
                    bypass_reg <= wr_data[0];
                end
                `PDC_ADDR_SIN: begin
                    doubler_reg <= wr_data[`PDC_DOUBLER_BIT];
                    sin_div_reg <= wr_data[`PDC_SIN_MSB:0];
                end
                `PDC_ADDR_OSC: begin
                    // The reserved code is stored and flagged so a bad write is visible.
                    osc_sel_reg <= wr_data[0];
                end
                default: begin
                    osc_sel_reg <= osc_sel_reg;
                end
            endcase
        end
    end

    // Read mux; reserved bits and unmapped addresses read as zero.
    always @* begin
        rd_data_next = 8'h00;
        case (reg_addr)
            `PDC_ADDR_FB_HI: begin
                rd_data_next = {fb_phase_reg, aux_pd_reg, fb_div_reg[11:8]};
            end
            `PDC_ADDR_FB_LO: begin
                rd_data_next = fb_div_reg[7:0];
            end
            `PDC_ADDR_AUX_LO: begin
                rd_data_next = aux_div_reg[7:0];
            end
            `PDC_ADDR_AUX_HI: begin
                rd_data_next = {aux_div_reg[8], 6'h00, fb_path_reg};
            end
            `PDC_ADDR_REF_HI: begin
                rd_data_next = {ref_phase_reg, 1'b0, ref_div_reg[11:8]};
            end
            `PDC_ADDR_REF_LO: begin
                rd_data_next = ref_div_reg[7:0];
            end
            `PDC_ADDR_SFB_HI: begin
                rd_data_next = {7'h00, sfb_div_reg[8]};
            end
            `PDC_ADDR_SFB_LO: begin
                rd_data_next = sfb_div_reg[7:0];
            end
            `PDC_ADDR_BYPASS: begin
                rd_data_next = {7'h00, bypass_reg};
            end
            `PDC_ADDR_SIN: begin
                rd_data_next = {doubler_reg, 1'b0, sin_div_reg};
            end
            `PDC_ADDR_OSC: begin
                rd_data_next = {7'h00, osc_sel_reg};
            end
            default: begin
                rd_data_next = 8'h00;
            end
        endcase
    end

    // Range check covers main, synth feedback and powered-up aux ratios and the oscillator code, but not the sample phases; the analog side sees raw codes.
    always @* begin
        range_error_next = 1'b0;
        if (fb_div_reg < `PDC_MIN_MAIN_DIV || ref_div_reg < `PDC_MIN_MAIN_DIV) begin
            range_error_next = 1'b1;
        end
        if (!aux_pd_reg && aux_div_reg < `PDC_MIN_AUX_DIV) begin
            range_error_next = 1'b1;
        end
        if (sfb_div_reg < `PDC_MIN_SFB_DIV) begin
            range_error_next = 1'b1;
        end
        if (osc_sel_reg) begin
            range_error_next = 1'b1;
        end
    end

    // Derived controls for the analog dividers, one cycle behind the registers.
    always @(posedge clk) begin
        if (srst) begin
            aux_divider_enable <= 1'b1;
            first_stage_loop_enable <= 1'b1;
            synth_ref_doubled <= 1'b0;
            synth_ref_div_bypass <= 1'b1;
            synth_ref_divide_eff <= `PDC_RST_SIN_DIV;
            config_range_error <= 1'b0;
        end else begin
            aux_divider_enable <= ~aux_pd_reg;
            first_stage_loop_enable <= ~bypass_reg;
            synth_ref_doubled <= doubler_reg;
            // The doubled path masks the pre-divider so a stale code cannot leak in.
            if (doubler_reg) begin
                synth_ref_divide_eff <= 6'h00;
                synth_ref_div_bypass <= 1'b1;
            end else begin
                synth_ref_divide_eff <= sin_div_reg;
                synth_ref_div_bypass <= (sin_div_reg == 6'h00);
            end
            config_range_error <= range_error_next;
        end
    end

    assign vcxo_loop_feedback_divide = fb_div_reg;
    assign feedback_divider_sample_phase = fb_phase_reg;
    assign aux_feedback_divide = aux_div_reg;
    assign aux_divider_powerdown = aux_pd_reg;
    assign feedback_path_extend = fb_path_reg;
    assign ref_divider_sample_phase = ref_phase_reg;
    assign ref_input_predivide = ref_div_reg;
    assign synth_feedback_predivide = sfb_div_reg;
    assign synth_input_predivide = sin_div_reg;
    assign doubler_select = doubler_reg;
    assign first_stage_bypass = bypass_reg;
    assign oscillator_select = osc_sel_reg;
endmodule

/* pdc_top_sva.sv */
// Purpose: Port-level checks of the divider configuration block.
// Assumes: One clock domain; srst is synchronous and active high.
// Notes: Register changes can only come from a serial frame, so a quiet cs_n freezes them.
`timescale 1ns/1ns
module pdc_top_sva (
    input wire clk,
    input wire srst,
    input wire spi_cs_n,
    input wire [11:0] vcxo_loop_feedback_divide,
    input wire [8:0] aux_feedback_divide,
    input wire aux_divider_powerdown,
    input wire [2:0] ref_divider_sample_phase,
    input wire [11:0] ref_input_predivide,
    input wire [8:0] synth_feedback_predivide,
    input wire [5:0] synth_input_predivide,
    input wire doubler_select,
    input wire first_stage_bypass,
    input wire oscillator_select,
    input wire aux_divider_enable,
    input wire first_stage_loop_enable,
    input wire synth_ref_doubled,
    input wire synth_ref_div_bypass,
    input wire [5:0] synth_ref_divide_eff,
    input wire config_range_error
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_reset_values: assert property ($fell(srst) |-> vcxo_loop_feedback_divide == 12'hc00
        && ref_input_predivide == 12'hc00 && aux_feedback_divide == 9'h060
        && synth_feedback_predivide == 9'h018 && synth_input_predivide == 6'h00
        && ref_divider_sample_phase == 3'h0 && !oscillator_select && !aux_divider_powerdown)
        else $error("reset value wrong");
    a_quiet_frozen: assert property (spi_cs_n [*4] |=> $stable({vcxo_loop_feedback_divide,
        aux_feedback_divide, ref_input_predivide, synth_feedback_predivide}))
        else $error("divider changed outside a frame");
    a_aux_power: assert property (aux_divider_enable == !$past(aux_divider_powerdown))
        else $error("aux enable does not follow power-down");
    a_aux_range: assert property (!aux_divider_powerdown && aux_feedback_divide < 9'h004
        |-> ##1 config_range_error) else $error("low aux ratio not flagged");
    a_doubled_flag: assert property (synth_ref_doubled == $past(doubler_select))
        else $error("doubled flag wrong");
    a_divider_path: assert property (!$past(doubler_select) |->
        synth_ref_divide_eff == $past(synth_input_predivide)
        && synth_ref_div_bypass == ($past(synth_input_predivide) == 6'h00))
        else $error("input divider path wrong");
    a_doubler_ignores: assert property ($past(doubler_select) |-> synth_ref_div_bypass
        && synth_ref_divide_eff == 6'h00) else $error("divider used while doubled");
    a_osc_reserved: assert property (oscillator_select |-> ##1 config_range_error)
        else $error("reserved oscillator code not flagged");
    a_loop_bypass: assert property (first_stage_loop_enable == !$past(first_stage_bypass))
        else $error("loop enable does not follow bypass");
endmodule
bind pdc_top pdc_top_sva pdc_top_sva_inst (.clk(clk), .srst(srst), .spi_cs_n(spi_cs_n),
    .vcxo_loop_feedback_divide(vcxo_loop_feedback_divide),
    .aux_feedback_divide(aux_feedback_divide), .aux_divider_powerdown(aux_divider_powerdown),
    .ref_divider_sample_phase(ref_divider_sample_phase),
    .ref_input_predivide(ref_input_predivide),
    .synth_feedback_predivide(synth_feedback_predivide),
    .synth_input_predivide(synth_input_predivide), .doubler_select(doubler_select),
    .first_stage_bypass(first_stage_bypass), .oscillator_select(oscillator_select),
    .aux_divider_enable(aux_divider_enable), .first_stage_loop_enable(first_stage_loop_enable),
    .synth_ref_doubled(synth_ref_doubled), .synth_ref_div_bypass(synth_ref_div_bypass),
    .synth_ref_divide_eff(synth_ref_divide_eff), .config_range_error(config_range_error));

/* pdc_top_test.sv */
// Purpose: Self-checking bench for the divider configuration block.
// Assumes: 50 MHz clk; serial half periods of five clk cycles.
// Notes: Outputs are checked after each frame has fully settled.
`timescale 1ns/1ns
module pdc_top_test;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg spi_sclk = 1'b0;
    reg spi_cs_n = 1'b1;
    reg spi_sdio_in = 1'b0;
    wire sdo, sdo_oe, aux_pd, path_ext, dbl, byp, osc, aux_en, loop_en, r_dbl, r_byp, rng_err;
    wire [11:0] fb_div, ref_div;
    wire [8:0] aux_div, sfb_div;
    wire [5:0] sin_div, r_eff;
    wire [2:0] fb_ph, ref_ph;
    integer error_cnt = 0;
    integer comparisons = 0;
    reg oe_seen = 1'b1;
    always #10 clk = ~clk;
    pdc_top pdc_top_inst (.clk(clk), .srst(srst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_sdio_in(spi_sdio_in), .spi_sdio_out(sdo), .spi_sdio_oe(sdo_oe),
        .vcxo_loop_feedback_divide(fb_div), .feedback_divider_sample_phase(fb_ph),
        .aux_feedback_divide(aux_div), .aux_divider_powerdown(aux_pd),
        .feedback_path_extend(path_ext), .ref_divider_sample_phase(ref_ph),
        .ref_input_predivide(ref_div), .synth_feedback_predivide(sfb_div),
        .synth_input_predivide(sin_div), .doubler_select(dbl), .first_stage_bypass(byp),
        .oscillator_select(osc), .aux_divider_enable(aux_en),
        .first_stage_loop_enable(loop_en), .synth_ref_doubled(r_dbl),
        .synth_ref_div_bypass(r_byp), .synth_ref_divide_eff(r_eff),
        .config_range_error(rng_err));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t ns: saw %h, wanted %h", $time, got, exp);
            end
        end
    endtask
    task xfer(input rd, input [6:0] a, input [7:0] d, output [7:0] q);
        reg [15:0] f;
        integer i;
        begin
            f = {rd, a, d};
            q = 8'h00;
            oe_seen = 1'b1;
            @(posedge clk);
            spi_cs_n <= 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                @(posedge clk);
                spi_sdio_in <= f[i];
                repeat (4) @(posedge clk);
                spi_sclk <= 1'b1;
                repeat (4) @(posedge clk);
                @(negedge clk);
                // The slave shifts on each falling edge, so a bit is taken in the high phase.
                if (rd && i > 0 && i < 9) begin
                    q[i - 1] = sdo;
                    oe_seen = oe_seen & sdo_oe;
                end
                @(posedge clk);
                spi_sclk <= 1'b0;
            end
            repeat (6) @(posedge clk);
            spi_cs_n <= 1'b1;
            repeat (8) @(posedge clk);
            @(negedge clk);
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        reg [7:0] q;
        begin
            xfer(1'b0, a, d, q);
        end
    endtask
    // Reads send a changing pattern in the data slot, so a stuck input cannot look right.
    task rd(input [6:0] a, input [7:0] exp);
        reg [7:0] q;
        begin
            xfer(1'b1, a, 8'h5a, q);
            chk(q, exp);
            chk({oe_seen, sdo_oe}, 16'h2);
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
            if (error_cnt == 0 && comparisons > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #500000;
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t ns: watchdog ran out", $time);
        test_done;
    end
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(fb_div, 16'hc00);
        chk(ref_div, 16'hc00);
        chk({aux_pd, aux_div}, 16'h060);
        chk({fb_ph, ref_ph}, 16'h00);
        chk({sin_div, sfb_div}, 16'h018);
        chk({dbl, r_dbl, r_byp, r_eff}, 16'h040);
        chk({osc, rng_err}, 16'h0);
        chk({byp, loop_en, aux_en}, 16'h3);
        rd(7'h00, 8'h0c);
        $display("test reset done");
        wr(7'h01, 8'hff);
        wr(7'h00, 8'hef);
        chk(fb_div, 16'hfff);
        rd(7'h00, 8'hef);
        wr(7'h05, 8'h01);
        wr(7'h04, 8'hef);
        chk(ref_div, 16'hf01);
        chk(ref_ph, 16'h7);
        rd(7'h04, 8'hef);
        $display("test main dividers done");
        wr(7'h02, 8'h03);
        chk({aux_div, rng_err}, 16'h007);
        wr(7'h00, 8'hff);
        chk({aux_pd, aux_en, rng_err}, 16'h4);
        wr(7'h03, 8'hff);
        chk({path_ext, aux_div}, 16'h303);
        rd(7'h03, 8'h81);
        $display("test aux divider done");
        wr(7'h08, 8'h01);
        wr(7'h09, 8'hff);
        chk(sfb_div, 16'h1ff);
        rd(7'h08, 8'h01);
        wr(7'h0c, 8'h3f);
        chk({r_dbl, r_byp, r_eff}, 16'h3f);
        wr(7'h0c, 8'hbf);
        chk({dbl, sin_div}, 16'h7f);
        chk({r_dbl, r_byp, r_eff}, 16'hc0);
        rd(7'h0c, 8'hbf);
        wr(7'h0c, 8'h00);
        chk({r_byp, r_eff}, 16'h40);
        $display("test second stage done");
        wr(7'h0a, 8'h01);
        chk({byp, loop_en}, 16'h2);
        wr(7'h1e, 8'hff);
        rd(7'h1e, 8'h00);
        chk(fb_div, 16'hfff);
        wr(7'h1f, 8'hfe);
        rd(7'h1f, 8'h00);
        wr(7'h1f, 8'h01);
        chk({osc, rng_err}, 16'h3);
        $display("test bypass and select done");
        test_done;
    end
endmodule
